/* File: src/pbu_pin_mux.sv */
// Purpose: dedicated-function multiplexing of port B bits 24 to 31
// Assumes: selectors and controller signals are on sys_clk; pads and
//          clear-to-send pins are asynchronous and get synchronised here
// Notes:   outputs are registered, inputs reach controllers 3 cycles late

// Notes on behaviour
// - bit 31: tx error, serial rxd, tdm b txd
// - bit 30: serial txd, rx dv, tdm b rxd
// - carrier without data valid flags broken header
// - bit 29: tx enable or tdm b rx sync
// - bit 28: rts, rx error, serial rts, sync
// - request low, granted only when cts low
// - ethernet mode turns serial rts into tx enable
// - bit 27: collision in or tdm c txd
// - bit 26: carrier sense or tdm c rxd
// - bit 25: txd3, tdm a txd3, c tx sync
// - bit 24: txd2, tdm a rxd3, c rx sync
module pbu_pin_mux (
  input  wire logic                     sys_clk,
  input  wire logic                     arst_n,
  // pad side, index 0 is bit 24
  input  wire logic [pbu_pkg::PBU_NUM_PINS-1:0] pin_in,
  output logic [pbu_pkg::PBU_NUM_PINS-1:0]      pin_out,
  output logic [pbu_pkg::PBU_NUM_PINS-1:0]      pin_oe,
  // port configuration
  input  wire logic [pbu_pkg::PBU_NUM_PINS-1:0] pin_dedicated,
  input  wire pbu_pkg::pbu_sel_t                pin_sel [pbu_pkg::PBU_NUM_PINS],
  input  wire logic                     scc_two_ethernet_mode,
  // fast controller two
  input  wire logic                     fast_comm_controller_two_tx_error,
  input  wire logic                     fast_comm_controller_two_tx_en,
  input  wire logic                     fast_comm_controller_two_rts_n,
  input  wire logic                     fast_comm_controller_two_cts_n,
  input  wire logic [1:0]               fast_comm_controller_two_txd_hi,
  output logic                          fast_comm_controller_two_rx_dv,
  output logic                          fast_comm_controller_two_rx_error,
  output logic                          fast_comm_controller_two_col,
  output logic                          fast_comm_controller_two_crs,
  output logic                          fast_comm_controller_two_broken_header,
  output logic                          fast_comm_controller_two_rts_granted,
  // serial controller two
  input  wire logic                     serial_comm_controller_two_txd,
  input  wire logic                     serial_comm_controller_two_rts_n,
  input  wire logic                     serial_comm_controller_two_cts_n,
  input  wire logic                     ethernet_tx_enable_out,
  output logic                          serial_comm_controller_two_rxd,
  output logic                          serial_comm_controller_two_rts_granted,
  // tdm channels of both serial interfaces
  input  wire logic                     tdm_channel_b_two_layer1_serial_tx_data,
  input  wire logic                     tdm_channel_c_two_layer1_serial_tx_data,
  input  wire logic                     tdm_channel_a_one_layer1_tx_nibble_msb,
  output logic                          tdm_channel_b_two_layer1_serial_rx_data,
  output logic                          tdm_channel_b_two_layer1_rx_sync,
  output logic                          tdm_channel_b_two_layer1_tx_sync,
  output logic                          tdm_channel_c_two_layer1_serial_rx_data,
  output logic                          tdm_channel_c_two_layer1_rx_sync,
  output logic                          tdm_channel_c_two_layer1_tx_sync,
  output logic                          tdm_channel_a_one_layer1_rx_nibble_msb
);
  import pbu_pkg::*;

  // ****************************************************************
  // output function values per pad
  // ****************************************************************
  pbu_fvec_t out_vals [PBU_NUM_PINS];
  pbu_fvec_t in_route [PBU_NUM_PINS];
  logic      scc_rts_pin;

  // ethernet mode reuses the request pin as transmit enable
  always_comb begin
    scc_rts_pin = scc_two_ethernet_mode ? ethernet_tx_enable_out
                                        : serial_comm_controller_two_rts_n;
    for (int p = 0; p < PBU_NUM_PINS; p++) begin
      out_vals[p] = '0;
    end
    out_vals[7][PBU_B31_TX_ERROR] = fast_comm_controller_two_tx_error;
    out_vals[7][PBU_B31_TDMB_TXD] = tdm_channel_b_two_layer1_serial_tx_data;
    out_vals[6][PBU_B30_SCC_TXD]  = serial_comm_controller_two_txd;
    out_vals[5][PBU_B29_TX_EN]    = fast_comm_controller_two_tx_en;
    out_vals[4][PBU_B28_FCC_RTS]  = fast_comm_controller_two_rts_n;
    out_vals[4][PBU_B28_SCC_RTS]  = scc_rts_pin;
    out_vals[3][PBU_B27_TDMC_TXD] = tdm_channel_c_two_layer1_serial_tx_data;
    out_vals[1][PBU_B25_TXD3]     = fast_comm_controller_two_txd_hi[1];
    out_vals[1][PBU_B25_TDMA_TX3] = tdm_channel_a_one_layer1_tx_nibble_msb;
    out_vals[0][PBU_B24_TXD2]     = fast_comm_controller_two_txd_hi[0];
  end

  // ****************************************************************
  // one slice per pad
  // ****************************************************************
  for (genvar g = 0; g < PBU_NUM_PINS; g++) begin : g_pin
    pbu_pin_slice #(
      .NUM_FUNC (PBU_FUNC_COUNT[g]),
      .OUT_MASK (PBU_OUT_MASK[g])
    ) u_slice (
      .sys_clk   (sys_clk),
      .arst_n    (arst_n),
      .dedicated (pin_dedicated[g]),
      .sel       (pin_sel[g]),
      .out_vals  (out_vals[g]),
      .pin_in    (pin_in[g]),
      .pin_out   (pin_out[g]),
      .pin_oe    (pin_oe[g]),
      .in_route  (in_route[g])
    );
  end

  // ****************************************************************
  // input functions to controllers
  // ****************************************************************
  // routed levels, each already registered inside its slice
  assign serial_comm_controller_two_rxd          = in_route[7][PBU_B31_SCC_RXD];
  assign fast_comm_controller_two_rx_dv          = in_route[6][PBU_B30_RX_DV];
  assign tdm_channel_b_two_layer1_serial_rx_data = in_route[6][PBU_B30_TDMB_RXD];
  assign tdm_channel_b_two_layer1_rx_sync        = in_route[5][PBU_B29_TDMB_RSY];
  assign fast_comm_controller_two_rx_error       = in_route[4][PBU_B28_RX_ER];
  assign tdm_channel_b_two_layer1_tx_sync        = in_route[4][PBU_B28_TDMB_TSY];
  assign fast_comm_controller_two_col            = in_route[3][PBU_B27_COL];
  assign fast_comm_controller_two_crs            = in_route[2][PBU_B26_CRS];
  assign tdm_channel_c_two_layer1_serial_rx_data = in_route[2][PBU_B26_TDMC_RXD];
  assign tdm_channel_c_two_layer1_tx_sync        = in_route[1][PBU_B25_TDMC_TSY];
  assign tdm_channel_a_one_layer1_rx_nibble_msb  = in_route[0][PBU_B24_TDMA_RX3];
  assign tdm_channel_c_two_layer1_rx_sync        = in_route[0][PBU_B24_TDMC_RSY];

  // ****************************************************************
  // status: broken headers and request grants
  // ****************************************************************
  logic fcts1_q, fcts1_d, fcts2_q, fcts2_d;
  logic scts1_q, scts1_d, scts2_q, scts2_d;
  logic broken_q, broken_d;
  logic fgrant_q, fgrant_d;
  logic sgrant_q, sgrant_d;

  // cts pins are asynchronous, two flops before use
  always_comb begin
    fcts1_d  = fast_comm_controller_two_cts_n;
    fcts2_d  = fcts1_q;
    scts1_d  = serial_comm_controller_two_cts_n;
    scts2_d  = scts1_q;
    // phy raises carrier on any cable activity; without data valid it is junk
    broken_d = fast_comm_controller_two_crs && !fast_comm_controller_two_rx_dv;
    // grant needs our request low and the partner's answer low
    fgrant_d = !fast_comm_controller_two_rts_n && !fcts2_q;
    // in ethernet mode the pin is a transmit enable, no handshake applies
    sgrant_d = !scc_two_ethernet_mode && !serial_comm_controller_two_rts_n
               && !scts2_q;
  end

  // status registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      fcts1_q  <= PBU_RST_CTS_N;
      fcts2_q  <= PBU_RST_CTS_N;
      scts1_q  <= PBU_RST_CTS_N;
      scts2_q  <= PBU_RST_CTS_N;
      broken_q <= PBU_RST_FLAG;
      fgrant_q <= PBU_RST_FLAG;
      sgrant_q <= PBU_RST_FLAG;
    end else begin
      fcts1_q  <= fcts1_d;
      fcts2_q  <= fcts2_d;
      scts1_q  <= scts1_d;
      scts2_q  <= scts2_d;
      broken_q <= broken_d;
      fgrant_q <= fgrant_d;
      sgrant_q <= sgrant_d;
    end
  end

  assign fast_comm_controller_two_broken_header  = broken_q;
  assign fast_comm_controller_two_rts_granted    = fgrant_q;
  assign serial_comm_controller_two_rts_granted  = sgrant_q;

  // ****************************************************************
  // assertions
  // ****************************************************************
  tx_error_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[7] && pin_sel[7] == PBU_B31_TX_ERROR)
    |=> (pin_oe[7] && pin_out[7] == $past(fast_comm_controller_two_tx_error)))
    else $error("tx error not on bit 31");

  scc_rxd_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[7] && pin_sel[7] == PBU_B31_SCC_RXD)[*4]
    |-> (serial_comm_controller_two_rxd == $past(pin_in[7], 3) && !pin_oe[7]))
    else $error("serial rxd not routed from bit 31");

  rx_dv_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[6] && pin_sel[6] == PBU_B30_RX_DV)[*4]
    |-> fast_comm_controller_two_rx_dv == $past(pin_in[6], 3))
    else $error("rx data valid not routed from bit 30");

  broken_header_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[6] && pin_sel[6] == PBU_B30_RX_DV
     && pin_dedicated[2] && pin_sel[2] == PBU_B26_CRS)[*5]
    |-> fast_comm_controller_two_broken_header == ($past(pin_in[2], 4) && !$past(pin_in[6], 4)))
    else $error("broken header flag wrong");

  tx_enable_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[5] && pin_sel[5] == PBU_B29_TX_EN)
    |=> (pin_oe[5] && pin_out[5] == $past(fast_comm_controller_two_tx_en)))
    else $error("tx enable not on bit 29");

  rts_grant_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    fast_comm_controller_two_rts_granted
    |-> (!$past(fast_comm_controller_two_rts_n) && !$past(fast_comm_controller_two_cts_n, 3)))
    else $error("request granted without cts low");

  ethernet_tx_enable_out_select_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[4] && pin_sel[4] == PBU_B28_SCC_RTS && scc_two_ethernet_mode)
    |=> (pin_oe[4] && pin_out[4] == $past(ethernet_tx_enable_out)))
    else $error("ethernet tx enable not on bit 28");

  tdmc_txd_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[3] && pin_sel[3] == PBU_B27_TDMC_TXD)
    |=> (pin_oe[3] && pin_out[3] == $past(tdm_channel_c_two_layer1_serial_tx_data)))
    else $error("tdm c txd not on bit 27");

  nibble_msb_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[1] && pin_sel[1] == PBU_B25_TXD3)
    |=> (pin_oe[1] && pin_out[1] == $past(fast_comm_controller_two_txd_hi[1])))
    else $error("txd3 not on bit 25");

  input_undriven_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (!pin_dedicated[0] || pin_sel[0] != PBU_B24_TXD2) |=> !pin_oe[0])
    else $error("bit 24 driven while not an output");

  // ****************************************************************
  // pad and route checks for the remaining functions, except the tdm b tx sync, tdm c syncs, tdm c rxd and tdm a rxd3 routes
  // ****************************************************************
  tdmb_txd_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[7] && pin_sel[7] == PBU_B31_TDMB_TXD)
    |=> (pin_oe[7]
         && pin_out[7] == $past(tdm_channel_b_two_layer1_serial_tx_data)))
    else $error("tdm b txd not on bit 31");

  scc_txd_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[6] && pin_sel[6] == PBU_B30_SCC_TXD)
    |=> (pin_oe[6]
         && pin_out[6] == $past(serial_comm_controller_two_txd)))
    else $error("serial txd not on bit 30");

  tdmb_rxd_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[6] && pin_sel[6] == PBU_B30_TDMB_RXD)[*4]
    |-> (tdm_channel_b_two_layer1_serial_rx_data == $past(pin_in[6], 3)
         && !pin_oe[6]))
    else $error("tdm b rxd not routed from bit 30");

  tdmb_rsync_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[5] && pin_sel[5] == PBU_B29_TDMB_RSY)[*4]
    |-> (tdm_channel_b_two_layer1_rx_sync == $past(pin_in[5], 3)
         && !pin_oe[5]))
    else $error("tdm b rx sync not routed from bit 29");

  fast_rts_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[4] && pin_sel[4] == PBU_B28_FCC_RTS)
    |=> (pin_oe[4]
         && pin_out[4] == $past(fast_comm_controller_two_rts_n)))
    else $error("fast rts not on bit 28");

  rx_error_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[4] && pin_sel[4] == PBU_B28_RX_ER)[*4]
    |-> (fast_comm_controller_two_rx_error == $past(pin_in[4], 3)
         && !pin_oe[4]))
    else $error("rx error not routed from bit 28");

  scc_rts_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[4] && pin_sel[4] == PBU_B28_SCC_RTS && !scc_two_ethernet_mode)
    |=> (pin_oe[4]
         && pin_out[4] == $past(serial_comm_controller_two_rts_n)))
    else $error("serial rts not on bit 28");

  col_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[3] && pin_sel[3] == PBU_B27_COL)[*4]
    |-> (fast_comm_controller_two_col == $past(pin_in[3], 3)
         && !pin_oe[3]))
    else $error("collision not routed from bit 27");

  crs_route_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[2] && pin_sel[2] == PBU_B26_CRS)[*4]
    |-> (fast_comm_controller_two_crs == $past(pin_in[2], 3)
         && !pin_oe[2]))
    else $error("carrier sense not routed from bit 26");

  tdma_tx3_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[1] && pin_sel[1] == PBU_B25_TDMA_TX3)
    |=> (pin_oe[1]
         && pin_out[1] == $past(tdm_channel_a_one_layer1_tx_nibble_msb)))
    else $error("tdm a txd3 not on bit 25");

  txd2_pad_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[0] && pin_sel[0] == PBU_B24_TXD2)
    |=> (pin_oe[0]
         && pin_out[0] == $past(fast_comm_controller_two_txd_hi[0])))
    else $error("txd2 not on bit 24");

  scc_grant_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    serial_comm_controller_two_rts_granted
    |-> (!$past(scc_two_ethernet_mode) && !$past(serial_comm_controller_two_rts_n)
         && !$past(serial_comm_controller_two_cts_n, 3)))
    else $error("serial request granted without cts low");

  idle_code_a: assert property (@(posedge sys_clk) disable iff (!arst_n)
    (pin_dedicated[5] && pin_sel[5] > PBU_B29_TDMB_RSY)
    |=> (!pin_oe[5] && !pin_out[5] && !tdm_channel_b_two_layer1_rx_sync))
    else $error("undefined code on bit 29 not idle");

endmodule

/* File: src/pbu_pkg.sv */
// Purpose: shared constants for the port B upper pin function multiplexer
// Assumes: pin index 0 is port bit 24, index 7 is port bit 31
// Notes:   function codes are the per-pin selector values
package pbu_pkg;

  // ****************************************************************
  // geometry
  // ****************************************************************
  localparam int PBU_NUM_PINS  = 8;
  localparam int PBU_MAX_FUNC  = 4;
  localparam int PBU_SEL_W     = 2;
  localparam int PBU_FIRST_BIT = 24;

  typedef logic [PBU_SEL_W-1:0]    pbu_sel_t;
  typedef logic [PBU_MAX_FUNC-1:0] pbu_fvec_t;

  // ****************************************************************
  // per-pin function tables, indexed by pin (0 = bit 24)
  // ****************************************************************
  localparam int PBU_FUNC_COUNT [PBU_NUM_PINS] = '{3, 3, 2, 2, 4, 2, 3, 3};
  // bit k set when function k drives the pin
  localparam pbu_fvec_t PBU_OUT_MASK [PBU_NUM_PINS] = '{
    4'h1, 4'h3, 4'h0, 4'h2, 4'h5, 4'h1, 4'h1, 4'h5};

  // ****************************************************************
  // function codes
  // ****************************************************************
  localparam pbu_sel_t PBU_B31_TX_ERROR = 2'h0;
  localparam pbu_sel_t PBU_B31_SCC_RXD  = 2'h1;
  localparam pbu_sel_t PBU_B31_TDMB_TXD = 2'h2;
  localparam pbu_sel_t PBU_B30_SCC_TXD  = 2'h0;
  localparam pbu_sel_t PBU_B30_RX_DV    = 2'h1;
  localparam pbu_sel_t PBU_B30_TDMB_RXD = 2'h2;
  localparam pbu_sel_t PBU_B29_TX_EN    = 2'h0;
  localparam pbu_sel_t PBU_B29_TDMB_RSY = 2'h1;
  localparam pbu_sel_t PBU_B28_FCC_RTS  = 2'h0;
  localparam pbu_sel_t PBU_B28_RX_ER    = 2'h1;
  localparam pbu_sel_t PBU_B28_SCC_RTS  = 2'h2;
  localparam pbu_sel_t PBU_B28_TDMB_TSY = 2'h3;
  localparam pbu_sel_t PBU_B27_COL      = 2'h0;
  localparam pbu_sel_t PBU_B27_TDMC_TXD = 2'h1;
  localparam pbu_sel_t PBU_B26_CRS      = 2'h0;
  localparam pbu_sel_t PBU_B26_TDMC_RXD = 2'h1;
  localparam pbu_sel_t PBU_B25_TXD3     = 2'h0;
  localparam pbu_sel_t PBU_B25_TDMA_TX3 = 2'h1;
  localparam pbu_sel_t PBU_B25_TDMC_TSY = 2'h2;
  localparam pbu_sel_t PBU_B24_TXD2     = 2'h0;
  localparam pbu_sel_t PBU_B24_TDMA_RX3 = 2'h1;
  localparam pbu_sel_t PBU_B24_TDMC_RSY = 2'h2;

  // ****************************************************************
  // reset values
  // ****************************************************************
  localparam logic PBU_RST_PIN_OUT = 1'b0;
  localparam logic PBU_RST_PIN_OE  = 1'b0;
  localparam logic PBU_RST_INPUT   = 1'b0;
  localparam logic PBU_RST_CTS_N   = 1'b1;
  localparam logic PBU_RST_FLAG    = 1'b0;

endpackage

/* File: src/pbu_pin_slice.sv */
// Purpose: one pad's function multiplexer with input synchroniser
// Assumes: selector and dedicated enable come from same-clock logic
// Notes:   undefined selector codes leave the pad undriven and inputs idle
module pbu_pin_slice #(
  parameter int              NUM_FUNC = 4,
  parameter pbu_pkg::pbu_fvec_t OUT_MASK = 4'h0
) (
  input  wire logic              sys_clk,
  input  wire logic              arst_n,
  input  wire logic              dedicated,
  input  wire pbu_pkg::pbu_sel_t sel,
  input  wire pbu_pkg::pbu_fvec_t out_vals,
  input  wire logic              pin_in,
  output logic                   pin_out,
  output logic                   pin_oe,
  output pbu_pkg::pbu_fvec_t     in_route
);
  import pbu_pkg::*;

  // ****************************************************************
  // elaboration check
  // ****************************************************************
  if (NUM_FUNC < 1 || NUM_FUNC > PBU_MAX_FUNC) begin : g_bad_count
    $error("pbu_pin_slice: function count out of range");
  end

  logic      sync1_q, sync1_d;
  logic      sync2_q, sync2_d;
  logic      out_q, out_d;
  logic      oe_q, oe_d;
  pbu_fvec_t route_q, route_d;
  logic      valid_sel;

  // next-state: one function owns the pad at a time
  always_comb begin
    valid_sel = dedicated && (int'(sel) < NUM_FUNC);
    sync1_d   = pin_in;
    sync2_d   = sync1_q;  // first stage feeds only this stage
    out_d     = valid_sel ? out_vals[sel] : PBU_RST_PIN_OUT;
    oe_d      = valid_sel && OUT_MASK[sel];
    for (int k = 0; k < PBU_MAX_FUNC; k++) begin
      // unselected inputs idle low so a peer never sees a stale level
      route_d[k] = valid_sel && (sel == PBU_SEL_W'(k)) && !OUT_MASK[k] && sync2_q;
    end
  end

  // registers
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      sync1_q <= PBU_RST_INPUT;
      sync2_q <= PBU_RST_INPUT;
      out_q   <= PBU_RST_PIN_OUT;
      oe_q    <= PBU_RST_PIN_OE;
      route_q <= '0;
    end else begin
      sync1_q <= sync1_d;
      sync2_q <= sync2_d;
      out_q   <= out_d;
      oe_q    <= oe_d;
      route_q <= route_d;
    end
  end

  assign pin_out  = out_q;
  assign pin_oe   = oe_q;
  assign in_route = route_q;

endmodule

/* File: bench/pbu_far_side.sv */
// Purpose: far side of the upper port B pads: phy, serial peer, tdm highway
// Assumes: bench hands in the levels the far parties put on their pads
// Notes:   clear-to-send answers the rts pad, promptly or three cycles late
module pbu_far_side (
  input  wire logic       sys_clk,
  input  wire logic       arst_n,
  input  wire logic [7:0] pin_out,
  input  wire logic [7:0] pin_oe,
  input  wire logic [7:0] far_lvl,
  input  wire logic       deny,
  input  wire logic       slow,
  output logic      [7:0] pad,
  output logic            cts_n
);
  timeunit 1ns;
  timeprecision 1ps;

  // ****************************************************************
  // wire level
  // ****************************************************************
  logic [2:0] wait_q;

  // device wins where it drives, far side elsewhere; col and crs come from far_lvl
  assign pad = (pin_oe & pin_out) | (~pin_oe & far_lvl);

  // ****************************************************************
  // request to send handshake
  // ****************************************************************
  // grant only while the rts pad is driven low; deny models a busy peer
  always_ff @(posedge sys_clk or negedge arst_n) begin
    if (!arst_n) begin
      wait_q <= 3'h0;
      cts_n  <= 1'b1;
    end else if (pin_oe[4] && !pin_out[4] && !deny) begin
      if (wait_q >= (slow ? 3'h3 : 3'h0)) begin
        cts_n <= 1'b0;
      end else begin
        wait_q <= wait_q + 3'h1;
      end
    end else begin
      wait_q <= 3'h0;
      cts_n  <= 1'b1;
    end
  end
endmodule

/* File: bench/tb.sv */
// Purpose: self-checking bench for the upper port B pin multiplexer
// Assumes: stimulus is held 12 cycles, longer than the 3-cycle input sync
// Notes:   every code of every pad is swept, then random mixes follow
module tb;
  timeunit 1ns;
  timeprecision 1ps;
  import pbu_pkg::*;

  // ****************************************************************
  // signals
  // ****************************************************************
  logic        sys_clk = 1'b0;
  logic        arst_n  = 1'b0;
  logic [7:0]  pin_in, pin_out, pin_oe, ded, far_lvl;
  pbu_sel_t    sel [PBU_NUM_PINS];
  logic        eth, f_txer, f_txen, f_rts_n, s_txd, s_rts_n, s_txen;
  logic        tb_txd, tc_txd, ta_tx3, deny, slow, cts_n, bh, fg, sg;
  logic [1:0]  f_txd;
  logic [11:0] rt;
  int          n_mismatch   = 0;
  int          total_checks = 0;
  int          cyc          = 0;
  // pad and code of each routed input, in the order of rt
  localparam int RP [12] = '{6, 4, 3, 2, 7, 6, 5, 4, 2, 0, 1, 0};
  localparam int RC [12] = '{1, 1, 0, 0, 1, 2, 1, 3, 1, 2, 2, 1};

  always #2 sys_clk = ~sys_clk;

  pbu_far_side i_far (
    .sys_clk (sys_clk), .arst_n (arst_n), .pin_out (pin_out), .pin_oe (pin_oe),
    .far_lvl (far_lvl), .deny (deny), .slow (slow), .pad (pin_in), .cts_n (cts_n));

  pbu_pin_mux i_dut (
    .sys_clk (sys_clk), .arst_n (arst_n), .pin_in (pin_in), .pin_out (pin_out),
    .pin_oe (pin_oe), .pin_dedicated (ded), .pin_sel (sel), .scc_two_ethernet_mode (eth),
    .fast_comm_controller_two_tx_error (f_txer), .fast_comm_controller_two_tx_en (f_txen),
    .fast_comm_controller_two_rts_n (f_rts_n), .fast_comm_controller_two_cts_n (cts_n),
    .fast_comm_controller_two_txd_hi (f_txd), .fast_comm_controller_two_rx_dv (rt[0]),
    .fast_comm_controller_two_rx_error (rt[1]), .fast_comm_controller_two_col (rt[2]),
    .fast_comm_controller_two_crs (rt[3]), .fast_comm_controller_two_broken_header (bh),
    .fast_comm_controller_two_rts_granted (fg), .serial_comm_controller_two_txd (s_txd),
    .serial_comm_controller_two_rts_n (s_rts_n), .serial_comm_controller_two_cts_n (cts_n),
    .ethernet_tx_enable_out (s_txen), .serial_comm_controller_two_rxd (rt[4]),
    .serial_comm_controller_two_rts_granted (sg),
    .tdm_channel_b_two_layer1_serial_tx_data (tb_txd),
    .tdm_channel_c_two_layer1_serial_tx_data (tc_txd),
    .tdm_channel_a_one_layer1_tx_nibble_msb (ta_tx3),
    .tdm_channel_b_two_layer1_serial_rx_data (rt[5]), .tdm_channel_b_two_layer1_rx_sync (rt[6]),
    .tdm_channel_b_two_layer1_tx_sync (rt[7]), .tdm_channel_c_two_layer1_serial_rx_data (rt[8]),
    .tdm_channel_c_two_layer1_rx_sync (rt[9]), .tdm_channel_c_two_layer1_tx_sync (rt[10]),
    .tdm_channel_a_one_layer1_rx_nibble_msb (rt[11]));

  // ****************************************************************
  // expectations
  // ****************************************************************
  // {drives, value} of pad p under code c; codes beyond the list leave it idle
  function automatic logic [1:0] exp_drv(input int p, input logic [1:0] c);
    logic o;
    logic v;
    o = 1'b1;
    v = 1'b0;
    case ({p[2:0], c})
      5'h1c:   v = f_txer;
      5'h1e:   v = tb_txd;
      5'h18:   v = s_txd;
      5'h14:   v = f_txen;
      5'h10:   v = f_rts_n;
      5'h12:   v = eth ? s_txen : s_rts_n;
      5'h0d:   v = tc_txd;
      5'h04:   v = f_txd[1];
      5'h05:   v = ta_tx3;
      5'h00:   v = f_txd[0];
      default: o = 1'b0;
    endcase
    return {o & ded[p], v & o & ded[p]};
  endfunction

  task automatic chk(input logic [11:0] got, input logic [11:0] exp);
    total_checks++;
    if (got !== exp) begin
      n_mismatch++;
      $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask

  task automatic check_all();
    logic [7:0]  eo;
    logic [7:0]  ev;
    logic [11:0] er;
    logic [1:0]  d;
    for (int p = 0; p < 8; p++) begin
      d     = exp_drv(p, sel[p]);
      eo[p] = d[1];
      ev[p] = d[0];
    end
    // unselected inputs read 0
    for (int k = 0; k < 12; k++) begin
      er[k] = ded[RP[k]] && (sel[RP[k]] == RC[k]) && far_lvl[RP[k]];
    end
    chk({4'h0, pin_oe}, {4'h0, eo});
    chk({4'h0, pin_out}, {4'h0, ev});
    chk(rt, er);
    chk({11'h0, bh}, {11'h0, er[3] & ~er[0]});
    chk({10'h0, fg, sg}, {10'h0, ~f_rts_n & ~cts_n, ~eth & ~s_rts_n & ~cts_n});
  endtask

  // ****************************************************************
  // stimulus
  // ****************************************************************
  // random mix; pad p, if given, is forced to code c
  task automatic stim(input int p, input int c);
    @(negedge sys_clk);
    ded     = 8'($urandom);
    far_lvl = 8'($urandom);
    f_txd   = 2'($urandom);
    {eth, f_txer, f_txen, f_rts_n, s_txd, s_rts_n} = 6'($urandom);
    {s_txen, tb_txd, tc_txd, ta_tx3, deny, slow}   = 6'($urandom);
    for (int q = 0; q < 8; q++) begin
      sel[q] = pbu_sel_t'($urandom_range(3, 0));
    end
    if (p >= 0) begin
      ded[p] = 1'b1;
      sel[p] = c[1:0];
    end
    repeat (12) @(negedge sys_clk);
    check_all();
  endtask

  // corner: carrier up on bit 26 with data valid on bit 30 low or high
  task automatic stim_bh(input logic dv);
    @(negedge sys_clk);
    ded[6]     = 1'b1;
    ded[2]     = 1'b1;
    sel[6]     = PBU_B30_RX_DV;
    sel[2]     = PBU_B26_CRS;
    far_lvl[6] = dv;
    far_lvl[2] = 1'b1;
    repeat (12) @(negedge sys_clk);
    check_all();
  endtask

  task automatic wrap_up();
    $display("checks=%0d mismatches=%0d", total_checks, n_mismatch);
    if (n_mismatch == 0 && total_checks > 0) begin
      $display("No errors found");
    end else begin
      $display("Errors were found");
    end
    $finish;
  endtask

  // hang guard, well above the ~2400 cycles the run needs
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 6000) begin
      n_mismatch++;
      wrap_up();
    end
  end

  initial begin
    void'($urandom(98));
    ded     = 8'h00;
    far_lvl = 8'h00;
    f_txd   = 2'h0;
    {eth, f_txer, f_txen, s_txd, s_txen, tb_txd, tc_txd, ta_tx3, deny, slow} = 10'h000;
    f_rts_n = 1'b1;
    s_rts_n = 1'b1;
    for (int q = 0; q < 8; q++) begin
      sel[q] = 2'h0;
    end
    repeat (6) @(posedge sys_clk);
    @(negedge sys_clk);
    arst_n = 1'b1;
    // every code of every pad, undefined ones included
    for (int p = 0; p < 8; p++) begin
      for (int c = 0; c < 4; c++) begin
        stim(p, c);
      end
    end
    stim_bh(1'b0);
    stim_bh(1'b1);
    repeat (150) stim(-1, 0);
    // reset in mid-run must release every pad by the next negedge, one cycle later
    @(negedge sys_clk);
    ded    = 8'hff;
    arst_n = 1'b0;
    @(negedge sys_clk);
    chk({4'h0, pin_oe}, 12'h000);
    chk(rt, 12'h000);
    chk({4'h0, pin_out}, 12'h000);
    chk({9'h0, bh, fg, sg}, 12'h000);
    arst_n = 1'b1;
    stim(-1, 0);
    wrap_up();
  end
endmodule
